// ---- rtl/ppc_consts.svh ----
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH

`define PPC_ADDR_P2_DATA    8'hA0
`define PPC_ADDR_P2_OTYPE   8'hA6
`define PPC_ADDR_P1_BYPASS  8'hD5
`define PPC_ADDR_P2_BYPASS  8'hD6
`define PPC_ADDR_P2_DIGSEL  8'hF3
`define PPC_ADDR_P1_DRIVE   8'hFA

`define PPC_PAGE_CONFIG     8'h0F

`define PPC_RST_P2_DATA     8'hFF
`define PPC_RST_P2_OTYPE    8'h00
`define PPC_RST_P1_BYPASS   8'h00
`define PPC_RST_P2_BYPASS   8'h00
`define PPC_RST_P2_DIGSEL   8'hFF
`define PPC_RST_P1_DRIVE    8'h00
`define PPC_RST_SYNC        8'h00
`define PPC_RST_RDATA       8'h00
`define PPC_RST_BIT_RDATA   1'b0
`define PPC_RST_PIN_OUT     8'h00
`define PPC_RST_PIN_OE      8'h00

`define PPC_BIT_BASE_POS    3

`endif

// ---- rtl/ppc_pkg.sv ----
package ppc_pkg;

    typedef logic [7:0] ppc_byte_t;

    typedef struct packed {
        ppc_byte_t data_latch;
        ppc_byte_t output_type;
        ppc_byte_t p1_bypass;
        ppc_byte_t p2_bypass;
        ppc_byte_t digital_select;
        ppc_byte_t p1_drive;
        ppc_byte_t pin_sync1;
        ppc_byte_t pin_sync2;
        ppc_byte_t rdata;
        logic      bit_rdata;
        ppc_byte_t pin_out;
        ppc_byte_t pin_oe;
        ppc_byte_t pullup_en;
        ppc_byte_t receiver_en;
    } ppc_state_s;

endpackage

// ---- rtl/ppc_top.sv ----
// Summary of operation
// - Skip bit one makes crossbar pass pin
// - Drive bit selects low or high strength
// - Data write loads latch, read returns pins
// - Read gives 0 low, 1 high
// - Input bit zero makes pin fully analog
// - Output bit: 0 open-drain, 1 push-pull
// - Output mode ignored for analog pins
// - Data register on all pages, bit addressable
`timescale 1ns/1ps
`include "ppc_consts.svh"

module ppc_top (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_page,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic [7:0] bit_addr,
    input  wire logic       bit_wr,
    input  wire logic       bit_wdata,
    input  wire logic       bit_rd,
    output logic            bit_rdata,
    input  wire logic [7:0] xbar_p2_assigned,
    input  wire logic [7:0] xbar_p2_out,
    input  wire logic [7:0] xbar_p2_oe,
    output logic      [7:0] p1_skip,
    output logic      [7:0] p2_skip,
    output logic      [7:0] p1_drive_high,
    input  wire logic [7:0] second_port_pin_in,
    output logic      [7:0] second_port_pin_out,
    output logic      [7:0] second_port_pin_oe,
    output logic      [7:0] p2_pullup_en,
    output logic      [7:0] p2_receiver_en,
    output logic      [7:0] p2_pin_read
);

    // Whole module state, registered once per clock
    ppc_pkg::ppc_state_s state;
    ppc_pkg::ppc_state_s next_state;

    // Register hit on the byte bus, optionally restricted to the config page
    function automatic logic reg_hit(
        input logic [7:0] addr,
        input logic [7:0] page,
        input logic [7:0] offset,
        input logic       any_page
    );
        reg_hit = (addr == offset) && (any_page || (page == `PPC_PAGE_CONFIG));
    endfunction

    // Bit address falls inside the data register's eight bit slots
    function automatic logic bit_hit(input logic [7:0] addr);
        logic [7:0] base;
        base    = `PPC_ADDR_P2_DATA;
        bit_hit = (addr[7:`PPC_BIT_BASE_POS] == base[7:`PPC_BIT_BASE_POS]);
    endfunction

    // Open-drain drives only a low level, push-pull drives both levels
    function automatic logic [1:0] drive_pair(
        input logic push_pull,
        input logic value,
        input logic enable
    );
        logic out_level;
        logic out_enable;

        if (push_pull) begin
            out_level  = value;
            out_enable = enable;
        end else begin
            out_level  = 1'b0;
            out_enable = enable & ~value;
        end
        drive_pair = {out_level, out_enable};
    endfunction

    // Decoded strobes and pin-path selects
    logic       hit_data;
    logic       hit_otype;
    logic       hit_p1_bypass;
    logic       hit_p2_bypass;
    logic       hit_digsel;
    logic       hit_p1_drive;
    logic [7:0] pin_value;
    logic [7:0] src_out;
    logic [7:0] src_oe;
    logic [7:0] use_latch;

    always_comb begin
        // Data latch answers on every page
        hit_data      = reg_hit(sfr_addr, sfr_page, `PPC_ADDR_P2_DATA, 1'b1);
        hit_otype     = reg_hit(sfr_addr, sfr_page, `PPC_ADDR_P2_OTYPE, 1'b0);
        hit_p1_bypass = reg_hit(sfr_addr, sfr_page, `PPC_ADDR_P1_BYPASS, 1'b0);
        hit_p2_bypass = reg_hit(sfr_addr, sfr_page, `PPC_ADDR_P2_BYPASS, 1'b0);
        hit_digsel    = reg_hit(sfr_addr, sfr_page, `PPC_ADDR_P2_DIGSEL, 1'b0);
        hit_p1_drive  = reg_hit(sfr_addr, sfr_page, `PPC_ADDR_P1_DRIVE, 1'b0);

        // Analog pins have no digital receiver, so they read low
        pin_value = state.pin_sync2 & state.digital_select;

        // Skipped or unassigned pins fall back to the software latch
        use_latch = state.p2_bypass | ~xbar_p2_assigned;
        src_out   = (use_latch & state.data_latch) | (~use_latch & xbar_p2_out);
        src_oe    = ~use_latch & xbar_p2_oe;
    end

    always_comb begin
        // Hold the six setting registers unless a strobe changes them; the others are reloaded every cycle below
        next_state = state;

        // Two-stage synchroniser on the raw pin levels
        next_state.pin_sync1 = second_port_pin_in;
        next_state.pin_sync2 = state.pin_sync1;

        // Byte writes, page-checked except the data latch
        if (sfr_wr) begin
            if (hit_data) begin
                next_state.data_latch = sfr_wdata;
            end else if (hit_otype) begin
                next_state.output_type = sfr_wdata;
            end else if (hit_p1_bypass) begin
                next_state.p1_bypass = sfr_wdata;
            end else if (hit_p2_bypass) begin
                next_state.p2_bypass = sfr_wdata;
            end else if (hit_digsel) begin
                next_state.digital_select = sfr_wdata;
            end else if (hit_p1_drive) begin
                next_state.p1_drive = sfr_wdata;
            end
        end

        // Single-bit writes touch only the addressed latch bit
        if (bit_wr && bit_hit(bit_addr)) begin
            next_state.data_latch[bit_addr[2:0]] = bit_wdata;
        end

        // Read data stands one cycle, zero when idle
        next_state.rdata = 8'h00;
        if (sfr_rd) begin
            if (hit_data) begin
                next_state.rdata = pin_value;
            end else if (hit_otype) begin
                next_state.rdata = state.output_type;
            end else if (hit_p1_bypass) begin
                next_state.rdata = state.p1_bypass;
            end else if (hit_p2_bypass) begin
                next_state.rdata = state.p2_bypass;
            end else if (hit_digsel) begin
                next_state.rdata = state.digital_select;
            end else if (hit_p1_drive) begin
                next_state.rdata = state.p1_drive;
            end
        end

        // Bit reads return the synchronised pin level
        next_state.bit_rdata = 1'b0;
        if (bit_rd && bit_hit(bit_addr)) begin
            next_state.bit_rdata = pin_value[bit_addr[2:0]];
        end

        // Pin drivers, one cycle after the settings change
        for (int i = 0; i < 8; i++) begin
            if (!state.digital_select[i]) begin
                // Analog pin: driver off regardless of output type
                next_state.pin_out[i] = 1'b0;
                next_state.pin_oe[i]  = 1'b0;
            end else if (use_latch[i]) begin
                {next_state.pin_out[i], next_state.pin_oe[i]} =
                    drive_pair(state.output_type[i], src_out[i], 1'b1);
            end else begin
                {next_state.pin_out[i], next_state.pin_oe[i]} =
                    drive_pair(state.output_type[i], src_out[i], src_oe[i]);
            end
        end

        // Pad controls follow the digital select one cycle later
        next_state.pullup_en   = state.digital_select;
        next_state.receiver_en = state.digital_select;
    end

    // Synchronous reset loads the power-on values
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state.pin_sync1      <= `PPC_RST_SYNC;
            state.pin_sync2      <= `PPC_RST_SYNC;
            state.rdata          <= `PPC_RST_RDATA;
            state.bit_rdata      <= `PPC_RST_BIT_RDATA;
            state.pin_out        <= `PPC_RST_PIN_OUT;
            state.pin_oe         <= `PPC_RST_PIN_OE;
            state.data_latch     <= `PPC_RST_P2_DATA;
            state.output_type    <= `PPC_RST_P2_OTYPE;
            state.p1_bypass      <= `PPC_RST_P1_BYPASS;
            state.p2_bypass      <= `PPC_RST_P2_BYPASS;
            state.digital_select <= `PPC_RST_P2_DIGSEL;
            state.p1_drive       <= `PPC_RST_P1_DRIVE;
            state.pullup_en      <= `PPC_RST_P2_DIGSEL;
            state.receiver_en    <= `PPC_RST_P2_DIGSEL;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state register, except p2_pin_read, which gates pin_sync2 with digital_select
    assign sfr_rdata           = state.rdata;
    assign bit_rdata           = state.bit_rdata;
    assign p1_skip             = state.p1_bypass;
    assign p2_skip             = state.p2_bypass;
    assign p1_drive_high       = state.p1_drive;
    assign second_port_pin_out = state.pin_out;
    assign second_port_pin_oe  = state.pin_oe;
    assign p2_pullup_en        = state.pullup_en;
    assign p2_receiver_en      = state.receiver_en;
    assign p2_pin_read         = pin_value;

endmodule

// ---- test/ppc_assertions.sv ----
`timescale 1ns/1ps
module ppc_chk (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] bit_addr,
    input wire logic       bit_rd,
    input wire logic       bit_rdata,
    input wire logic [7:0] p1_skip,
    input wire logic [7:0] p2_skip,
    input wire logic [7:0] p1_drive_high,
    input wire logic [7:0] second_port_pin_oe,
    input wire logic [7:0] p2_receiver_en,
    input wire logic [7:0] p2_pin_read
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_RD_IDLE: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data not zero when idle");
    AST_P1_SKIP: assert property ((sfr_wr && sfr_page == 8'h0F && sfr_addr == 8'hD5)
        |=> p1_skip == $past(sfr_wdata)) else $error("first port bypass not loaded");
    AST_P2_SKIP: assert property ((sfr_wr && sfr_page == 8'h0F && sfr_addr == 8'hD6)
        |=> p2_skip == $past(sfr_wdata)) else $error("second port bypass not loaded");
    AST_DRIVE: assert property ((sfr_wr && sfr_page == 8'h0F && sfr_addr == 8'hFA)
        |=> p1_drive_high == $past(sfr_wdata)) else $error("drive level not loaded");
    AST_PAGE_GUARD: assert property ((sfr_wr && sfr_page != 8'h0F && sfr_addr == 8'hFA)
        |=> $stable(p1_drive_high)) else $error("write on wrong page took effect");
    AST_ANALOG_OFF: assert property ((second_port_pin_oe & ~p2_receiver_en) == 8'h00)
        else $error("analog pin is driven");
    AST_DATA_READ: assert property ((sfr_rd && sfr_addr == 8'hA0)
        |=> sfr_rdata == $past(p2_pin_read)) else $error("data read differs from pins");
    AST_BIT_READ: assert property ((bit_rd && bit_addr[7:3] == 5'h14) |=> bit_rdata ==
        |($past(p2_pin_read) & (8'h01 << ($past(bit_addr) & 8'h07))))
        else $error("bit read differs from pin");
    cover property (sfr_wr && sfr_addr == 8'hF3);
    cover property (bit_rd && bit_addr[7:3] == 5'h14);
    cover property (second_port_pin_oe == 8'h0F);
endmodule

bind ppc_top ppc_chk chk_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .bit_addr(bit_addr), .bit_rd(bit_rd), .bit_rdata(bit_rdata), .p1_skip(p1_skip),
    .p2_skip(p2_skip), .p1_drive_high(p1_drive_high),
    .second_port_pin_oe(second_port_pin_oe), .p2_receiver_en(p2_receiver_en),
    .p2_pin_read(p2_pin_read)
);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic       ref_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic       bit_wr = 1'b0, bit_wdata = 1'b1, bit_rd = 1'b0, bit_rdata;
    logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
    logic [7:0] second_port_pin_in = 8'hA5, xbar_p2_assigned = 8'h00;
    logic [7:0] xbar_p2_out = 8'hFF, xbar_p2_oe = 8'hFF;
    logic [7:0] sfr_rdata, p1_skip, p2_skip, p1_drive_high, second_port_pin_out;
    logic [7:0] second_port_pin_oe, p2_pullup_en, p2_receiver_en, p2_pin_read;
    logic [7:0] cfg [4] = '{8'hA6, 8'hD5, 8'hD6, 8'hFA};
    int         mismatches = 0;
    int         n_compared = 0;
    ppc_top dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wdata(bit_wdata), .bit_rd(bit_rd),
        .bit_rdata(bit_rdata), .xbar_p2_assigned(xbar_p2_assigned),
        .xbar_p2_out(xbar_p2_out), .xbar_p2_oe(xbar_p2_oe), .p1_skip(p1_skip),
        .p2_skip(p2_skip), .p1_drive_high(p1_drive_high),
        .second_port_pin_in(second_port_pin_in), .second_port_pin_out(second_port_pin_out),
        .second_port_pin_oe(second_port_pin_oe), .p2_pullup_en(p2_pullup_en),
        .p2_receiver_en(p2_receiver_en), .p2_pin_read(p2_pin_read)
    );
    always #10 ref_clk = ~ref_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick;
        @(posedge ref_clk) #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        {sfr_addr, sfr_page, sfr_wdata, sfr_wr} = {a, p, d, 1'b1};
        @(posedge ref_clk) #1 sfr_wr = 1'b0;
        tick;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
        {sfr_addr, sfr_page, sfr_rd} = {a, p, 1'b1};
        @(posedge ref_clk) #1 sfr_rd = 1'b0;
        chk(sfr_rdata, e);
        tick;
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        // Reset values, unmapped place
        rd(8'hA6, 8'h0F, 8'h00);
        rd(8'hD5, 8'h0F, 8'h00);
        rd(8'hD6, 8'h0F, 8'h00);
        rd(8'hF3, 8'h0F, 8'hFF);
        rd(8'hFA, 8'h0F, 8'h00);
        rd(8'hA0, 8'h00, 8'hA5);
        rd(8'h77, 8'h0F, 8'h00);
        $display("test reset done");
        foreach (cfg[i]) begin
            wr(cfg[i], 8'h0F, 8'h3C);
            rd(cfg[i], 8'h0F, 8'h3C);
        end
        chk(p1_skip, 8'h3C);
        chk(p2_skip, 8'h3C);
        chk(p1_drive_high, 8'h3C);
        wr(8'hFA, 8'h00, 8'hFF);
        rd(8'hFA, 8'h0F, 8'h3C);
        rd(8'hFA, 8'h00, 8'h00);
        $display("test config done");
        wr(8'hD6, 8'h0F, 8'h0C);
        chk(p2_skip, 8'h0C);
        second_port_pin_in = 8'hFF;
        wr(8'hF3, 8'h0F, 8'h0F);
        tick;
        chk(p2_receiver_en, 8'h0F);
        chk(p2_pullup_en, 8'h0F);
        chk(p2_pin_read, 8'h0F);
        chk(second_port_pin_out, 8'h0C);
        chk(second_port_pin_oe, 8'h0C);
        rd(8'hA0, 8'h33, 8'h0F);
        wr(8'hA0, 8'h00, 8'h00);
        tick;
        chk(second_port_pin_out, 8'h00);
        chk(second_port_pin_oe, 8'h0F);
        xbar_p2_assigned = 8'hFF;
        tick;
        chk(second_port_pin_oe, 8'h0C);
        $display("test pins done");
        {bit_addr, bit_wr} = {8'hA2, 1'b1};
        tick;
        bit_wr = 1'b0;
        tick;
        chk(second_port_pin_out, 8'h04);
        {bit_addr, bit_rd} = {8'hA3, 1'b1};
        tick;
        chk({7'h00, bit_rdata}, 8'h01);
        bit_addr = 8'hA5;
        tick;
        bit_rd = 1'b0;
        chk({7'h00, bit_rdata}, 8'h00);
        $display("test bits done");
        rst_n = 1'b0;
        repeat (2) tick;
        rst_n = 1'b1;
        rd(8'hF3, 8'h0F, 8'hFF);
        rd(8'hD6, 8'h0F, 8'h00);
        chk(p1_drive_high, 8'h00);
        $display("test reset again done");
        report_and_stop();
    end
endmodule
